//--- hdl/dma_ctrl_defines.svh
/*
 * Offsets, field positions, reset values and codes of the DMA control block.
 * Assumes byte addresses on the plain register port, one 32-bit word per register.
 */
`ifndef DMA_CTRL_DEFINES_SVH
`define DMA_CTRL_DEFINES_SVH

// ============================================================
// register port
`define ADDR_W 8
`define DATA_W 32
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_CDESC 8'h08

// ============================================================
// engine_control_reg fields
`define CTRL_SRST 2
`define CTRL_IOC_EN 12
`define CTRL_DLY_EN 13
`define CTRL_ERR_EN 14
`define HOLD_LSB 24
`define HOLD_W 8
`define CTRL_RST 32'h0000_0000
`define CTRL_WMASK 32'hff00_7000

// ============================================================
// engine_status_reg fields
`define STAT_IDLE 1
`define STAT_MINT 4
`define STAT_MSLV 5
`define STAT_MDEC 6
`define STAT_CINT 8
`define STAT_CSLV 9
`define STAT_CDEC 10
`define STAT_IOC 12
`define STAT_DLY 13
`define HTS_LSB 24

// ============================================================
// misc
`define CDESC_RST 32'h0000_0000
`define BCNT_W 23
`define BCNT_ZERO 23'h00_0000
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`define RST_MIN_CYC 8
`define RST_OUT_MAX 3

`endif

//--- hdl/dma_ctrl_pkg.sv
/*
 * Types of the DMA control block: the packed state of the controller.
 * Assumes dma_ctrl_defines.svh on the include path.
 */
`include "dma_ctrl_defines.svh"

package dma_ctrl_pkg;

    // ============================================================
    // controller state
    typedef struct packed {
        logic [1:0] rrst_sync;
        logic [`DATA_W-1:0] ctrl;
        logic [`DATA_W-1:0] cdesc;
        logic [`HOLD_W-1:0] hold_cnt;
        logic [`HOLD_W-1:0] hold_tgt;
        logic ioc;
        logic dly;
        logic [2:0] mover_err;
        logic [2:0] chain_err;
        logic halted;
        logic idle;
        logic irq;
        logic reload;
        logic flush;
        logic [`DATA_W-1:0] rdata;
    } ctrl_state_type;

endpackage

//--- hdl/dma_irq_error_reset_ctrl.sv
/*
 * Delay timer, error halt and logging, and reset control of a descriptor-chain DMA engine.
 * Assumes the engine's data and descriptor sides run on mclk_i and report events as
 * one-cycle strobes; the register port shares mclk_i.
 */
// The register offsets and the address-and-strobe port were chosen for this implementation.
//
// Contract
// [R1] delay timer runs only when the hold count field is nonzero
// [R2] session start loads the programmed hold count into the timer target
// [R3] timer counts up every cycle the idle status bit is one
// [R4] timer is cleared and stopped while idle status bit is zero
// [R5] delay event when the idle count equals the programmed hold count
// [R6] after a delay event timer reads zero and waits for software clear
// [R7] on error halt, idle only after accepted transfers finish their data
// [R8] on error capture the failing descriptor address as current pointer
// [R9] with several errors only one descriptor pointer is recorded
// [R10] halt lasts until hardware reset or soft reset bit written one
// [R11] zero byte count command flags a mover internal error
// [R12] data SLVERR flags mover slave error, DECERR flags mover decode error
// [R13] fetched descriptor already complete flags chain internal error, stale
// [R14] descriptor SLVERR or DECERR flags chain slave or decode error
// [R15] chain error bits are kept only in the status register
// [R16] all interfaces run from the main transfer clock
// [R17] an asynchronous register clock must not exceed the main clock
// [R18] a synchronous register clock is the main clock itself
// [R19] either reset returns the whole block to power-on state
// [R20] each reset is synchronous to its clock, held eight clocks; here rstn_i clears the state asynchronously
// [R21] outputs reach reset state and recover within three clocks
// [R22] register-port reset acts within one plus five clocks
// [R23] interrupt is high while an enabled status event is logged
// [R24] each delay event reloads the coalescing threshold counter
// [R25] hold timer status field shows the live delay counter
`timescale 1ns/100ps
`default_nettype none
`include "dma_ctrl_defines.svh"

module dma_irq_error_reset_ctrl
    import dma_ctrl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic regport_rstn_i,
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic [`DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`DATA_W-1:0] reg_rdata_o,
    input wire logic session_start_i,
    input wire logic engine_idle_i,
    input wire logic xfer_outstanding_i,
    input wire logic ioc_event_i,
    input wire logic [`DATA_W-1:0] cur_desc_i,
    input wire logic cmd_valid_i,
    input wire logic [`BCNT_W-1:0] cmd_byte_count_i,
    input wire logic data_resp_valid_i,
    input wire logic [1:0] data_resp_i,
    input wire logic desc_fetch_valid_i,
    input wire logic desc_cmplt_i,
    input wire logic desc_resp_valid_i,
    input wire logic [1:0] desc_resp_i,
    output logic halt_o,
    output logic idle_o,
    output logic irq_o,
    output logic coalesce_reload_o,
    output logic engine_flush_o,
    output logic [2:0] desc_status_err_o
);

    // ============================================================
    // state
    ctrl_state_type q_ff;
    ctrl_state_type nxt_q;

    logic [2:0] mover_ev;
    logic [2:0] chain_ev;
    logic new_err;
    logic soft_rst;
    logic timer_en;
    logic hit;
    logic [`HOLD_W-1:0] hold_field;
    logic [`DATA_W-1:0] stat_w;
    logic live;

    // ============================================================
    // event decode
    assign mover_ev[0] = cmd_valid_i && (cmd_byte_count_i == `BCNT_ZERO); // R11
    assign mover_ev[1] = data_resp_valid_i && (data_resp_i == `RESP_SLVERR); // R12
    assign mover_ev[2] = data_resp_valid_i && (data_resp_i == `RESP_DECERR); // R12
    assign chain_ev[0] = desc_fetch_valid_i && desc_cmplt_i; // R13
    assign chain_ev[1] = desc_resp_valid_i && (desc_resp_i == `RESP_SLVERR); // R14
    assign chain_ev[2] = desc_resp_valid_i && (desc_resp_i == `RESP_DECERR); // R14
    assign new_err = (|mover_ev) || (|chain_ev);

    assign soft_rst = reg_wr_i && (reg_addr_i == `OFF_CTRL) && reg_wdata_i[`CTRL_SRST]; // R10
    assign live = q_ff.rrst_sync[1] && !soft_rst;
    assign hold_field = q_ff.ctrl[`HOLD_LSB +: `HOLD_W];
    assign timer_en = (hold_field != 8'h00) && (q_ff.hold_tgt != 8'h00); // R1
    assign hit = (q_ff.hold_cnt + 8'h01) == q_ff.hold_tgt;

    always_comb begin
        stat_w = 32'h0000_0000;
        stat_w[`STAT_IDLE] = q_ff.idle;
        stat_w[`STAT_MINT] = q_ff.mover_err[0];
        stat_w[`STAT_MSLV] = q_ff.mover_err[1];
        stat_w[`STAT_MDEC] = q_ff.mover_err[2];
        stat_w[`STAT_CINT] = q_ff.chain_err[0];
        stat_w[`STAT_CSLV] = q_ff.chain_err[1];
        stat_w[`STAT_CDEC] = q_ff.chain_err[2];
        stat_w[`STAT_IOC] = q_ff.ioc;
        stat_w[`STAT_DLY] = q_ff.dly;
        stat_w[`HTS_LSB +: `HOLD_W] = q_ff.hold_cnt; // R25
    end

    // ============================================================
    // next state
    always_comb begin
        nxt_q = q_ff;
        nxt_q.rrst_sync = {q_ff.rrst_sync[0], regport_rstn_i}; // R22
        nxt_q.reload = 1'b0;
        nxt_q.flush = 1'b0;
        nxt_q.rdata = 32'h0000_0000;

        // error capture: first error wins the pointer
        if (new_err && !q_ff.halted) begin // R9
            nxt_q.cdesc = cur_desc_i; // R8
            nxt_q.halted = 1'b1; // R7
        end
        nxt_q.mover_err = q_ff.mover_err | mover_ev; // R11
        nxt_q.chain_err = q_ff.chain_err | chain_ev; // R15

        // idle only once every accepted transfer has drained
        if (q_ff.halted) begin
            nxt_q.idle = !xfer_outstanding_i; // R7
        end else begin
            nxt_q.idle = engine_idle_i && !xfer_outstanding_i;
        end

        if (session_start_i) begin
            nxt_q.hold_tgt = hold_field; // R2
        end

        // delay timer
        if (!q_ff.idle) begin
            nxt_q.hold_cnt = 8'h00; // R4
        end else if (timer_en && !q_ff.dly) begin
            if (hit) begin
                nxt_q.hold_cnt = 8'h00; // R6
                nxt_q.reload = 1'b1; // R24
            end else begin
                nxt_q.hold_cnt = q_ff.hold_cnt + 8'h01; // R3
            end
        end

        // register writes; a hardware set beats a software clear
        if (reg_wr_i) begin
            case (reg_addr_i)
                `OFF_CTRL: begin
                    nxt_q.ctrl = reg_wdata_i & `CTRL_WMASK;
                end
                `OFF_STAT: begin
                    nxt_q.ioc = q_ff.ioc && !reg_wdata_i[`STAT_IOC];
                    nxt_q.dly = q_ff.dly && !reg_wdata_i[`STAT_DLY]; // R6
                end
                `OFF_CDESC: begin
                    if (!new_err || q_ff.halted) begin
                        nxt_q.cdesc = reg_wdata_i;
                    end
                end
                default: begin
                end
            endcase
        end
        if (ioc_event_i) begin
            nxt_q.ioc = 1'b1;
        end
        if (q_ff.idle && timer_en && !q_ff.dly && hit) begin
            nxt_q.dly = 1'b1; // R5
        end

        if (reg_rd_i) begin
            case (reg_addr_i)
                `OFF_CTRL: nxt_q.rdata = q_ff.ctrl;
                `OFF_STAT: nxt_q.rdata = stat_w;
                `OFF_CDESC: nxt_q.rdata = q_ff.cdesc;
                default: nxt_q.rdata = 32'h0000_0000;
            endcase
        end

        nxt_q.irq = (q_ff.ioc && q_ff.ctrl[`CTRL_IOC_EN]) // R23
            || (q_ff.dly && q_ff.ctrl[`CTRL_DLY_EN])
            || ((|q_ff.mover_err || |q_ff.chain_err) && q_ff.ctrl[`CTRL_ERR_EN]);

        // register-port reset or soft reset return everything to power-on, except that the engine flush strobe is raised
        if (!live) begin
            nxt_q = '0; // R19
            nxt_q.rrst_sync = {q_ff.rrst_sync[0], regport_rstn_i};
            nxt_q.ctrl = `CTRL_RST;
            nxt_q.cdesc = `CDESC_RST;
            nxt_q.flush = 1'b1; // R10
        end
    end

    // single main clock drives all of the block
    always_ff @(posedge mclk_i or negedge rstn_i) begin // R16
        if (!rstn_i) begin
            q_ff <= '0; // R19 R21
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ============================================================
    // outputs
    assign reg_rdata_o = q_ff.rdata;
    assign halt_o = q_ff.halted;
    assign idle_o = q_ff.idle;
    assign irq_o = q_ff.irq;
    assign coalesce_reload_o = q_ff.reload;
    assign engine_flush_o = q_ff.flush;
    assign desc_status_err_o = q_ff.mover_err; // R15

    // ============================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    property p_timer_off;
        (live && hold_field == 8'h00 && q_ff.idle) |=> $stable(q_ff.hold_cnt);
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("timer moved while disabled"); // R1

    property p_tgt_load;
        (live && session_start_i) |=> (q_ff.hold_tgt == $past(hold_field));
    endproperty
    a_tgt_load: assert property (p_tgt_load) else $error("hold target not loaded"); // R2

    property p_count_up;
        (live && q_ff.idle && timer_en && !q_ff.dly && !hit)
            |=> (q_ff.hold_cnt == $past(q_ff.hold_cnt) + 8'h01);
    endproperty
    a_count_up: assert property (p_count_up) else $error("timer did not count"); // R3

    property p_busy_clear;
        (live && !q_ff.idle) |=> (q_ff.hold_cnt == 8'h00);
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("timer not cleared when busy"); // R4

    property p_dly_event;
        (live && q_ff.idle && timer_en && !q_ff.dly && hit)
            |=> (q_ff.dly && q_ff.hold_cnt == 8'h00 && coalesce_reload_o);
    endproperty
    a_dly_event: assert property (p_dly_event) else $error("delay event missing"); // R5

    property p_dly_hold;
        (live && q_ff.dly) |=> (q_ff.hold_cnt == 8'h00);
    endproperty
    a_dly_hold: assert property (p_dly_hold) else $error("timer ran before clear"); // R6

    property p_halt_idle;
        (live && q_ff.halted && xfer_outstanding_i) |=> !idle_o;
    endproperty
    a_halt_idle: assert property (p_halt_idle) else $error("idle before drain"); // R7

    property p_ptr_capture;
        (live && new_err && !q_ff.halted) |=> (q_ff.cdesc == $past(cur_desc_i)) && halt_o;
    endproperty
    a_ptr_capture: assert property (p_ptr_capture) else $error("pointer not captured"); // R8

    property p_ptr_once;
        (live && q_ff.halted && !(reg_wr_i && reg_addr_i == `OFF_CDESC)) |=> $stable(q_ff.cdesc);
    endproperty
    a_ptr_once: assert property (p_ptr_once) else $error("pointer overwritten"); // R9

    property p_halt_stays;
        (live && q_ff.halted) |=> halt_o;
    endproperty
    a_halt_stays: assert property (p_halt_stays) else $error("halt released"); // R10

    property p_zero_count;
        (live && cmd_valid_i && cmd_byte_count_i == `BCNT_ZERO) |=> q_ff.mover_err[0];
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count not flagged"); // R11

    property p_stale_desc;
        (live && desc_fetch_valid_i && desc_cmplt_i) |=> q_ff.chain_err[0] && halt_o;
    endproperty
    a_stale_desc: assert property (p_stale_desc) else $error("stale descriptor missed"); // R13

    property p_regrst;
        $fell(regport_rstn_i) |-> ##[1:3] (!irq_o && !halt_o && engine_flush_o);
    endproperty
    a_regrst: assert property (p_regrst) else $error("slow register-port reset"); // R21

    // ============================================================
    // error, interrupt, delay timer, idle and reset checks
    property p_mover_slv;
        (live && data_resp_valid_i && data_resp_i == `RESP_SLVERR)
            |=> (q_ff.mover_err[1] && halt_o);
    endproperty
    a_mover_slv: assert property (p_mover_slv) else $error("data slave error missed"); // R12

    property p_mover_dec;
        (live && data_resp_valid_i && data_resp_i == `RESP_DECERR)
            |=> (q_ff.mover_err[2] && halt_o);
    endproperty
    a_mover_dec: assert property (p_mover_dec) else $error("data decode error missed"); // R12

    property p_chain_slv;
        (live && desc_resp_valid_i && desc_resp_i == `RESP_SLVERR)
            |=> (q_ff.chain_err[1] && halt_o);
    endproperty
    a_chain_slv: assert property (p_chain_slv) else $error("chain slave error missed"); // R14

    property p_chain_dec;
        (live && desc_resp_valid_i && desc_resp_i == `RESP_DECERR)
            |=> (q_ff.chain_err[2] && halt_o);
    endproperty
    a_chain_dec: assert property (p_chain_dec) else $error("chain decode error missed"); // R14

    property p_wb_mover;
        (live && !cmd_valid_i && !data_resp_valid_i) |=> $stable(desc_status_err_o);
    endproperty
    a_wb_mover: assert property (p_wb_mover) else $error("writeback bits moved"); // R15

    property p_irq_on;
        (live && q_ff.ioc && q_ff.ctrl[`CTRL_IOC_EN]) |=> irq_o;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("enabled event without irq"); // R23

    property p_irq_off;
        (live && !q_ff.ioc && !q_ff.dly && !(|q_ff.mover_err) && !(|q_ff.chain_err))
            |=> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without event"); // R23

    property p_ioc_set;
        (live && ioc_event_i) |=> q_ff.ioc;
    endproperty
    a_ioc_set: assert property (p_ioc_set) else $error("completion event lost"); // R23

    property p_reload_pulse;
        coalesce_reload_o |=> !coalesce_reload_o;
    endproperty
    a_reload_pulse: assert property (p_reload_pulse) else $error("reload longer than one cycle"); // R24

    property p_live_status;
        (live && reg_rd_i && reg_addr_i == `OFF_STAT)
            |=> (reg_rdata_o[`HTS_LSB +: `HOLD_W] == $past(q_ff.hold_cnt));
    endproperty
    a_live_status: assert property (p_live_status) else $error("hold status not live"); // R25

    property p_soft_rst;
        soft_rst |=> (engine_flush_o && !halt_o && !idle_o);
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset ignored"); // R10

    property p_err_keep;
        (live && (|q_ff.chain_err)) |=> (|q_ff.chain_err);
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("error bits lost before reset"); // R10

    property p_sync_rst;
        !q_ff.rrst_sync[1] |=> (engine_flush_o && !halt_o && !irq_o);
    endproperty
    a_sync_rst: assert property (p_sync_rst) else $error("register-port reset not applied"); // R22

    property p_idle_run;
        (live && !q_ff.halted)
            |=> (idle_o == $past(engine_idle_i && !xfer_outstanding_i));
    endproperty
    a_idle_run: assert property (p_idle_run) else $error("idle status wrong"); // R7

    property p_hw_rst;
        ($rose(rstn_i) && regport_rstn_i) |-> ##[1:3] !engine_flush_o;
    endproperty
    a_hw_rst: assert property (p_hw_rst) else $error("slow recovery from reset"); // R21

    property p_halt_first;
        (live && !q_ff.halted && !new_err) |=> !halt_o;
    endproperty
    a_halt_first: assert property (p_halt_first) else $error("halt without error"); // R7

endmodule // dma_irq_error_reset_ctrl

`default_nettype wire

//--- test/dma_engine_model.sv
/*
 * Far-side engine model: reports engine idle and outstanding data phases.
 * Assumes the clock and hardware reset of the block under test.
 */
`timescale 1ns/100ps
`default_nettype none

module dma_engine_model (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic busy_req_i,
    input wire logic [3:0] drain_i,
    output logic engine_idle_o,
    output logic xfer_outstanding_o
);
    logic [3:0] left_ff;

    // accepted data phases keep running for drain_i cycles after work stops
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            left_ff <= 4'h0;
        end else if (busy_req_i) begin
            left_ff <= drain_i;
        end else if (left_ff != 4'h0) begin
            left_ff <= left_ff - 4'h1;
        end
    end

    assign xfer_outstanding_o = busy_req_i || (left_ff != 4'h0);
    assign engine_idle_o = !xfer_outstanding_o;
endmodule // dma_engine_model

`default_nettype wire

//--- test/test_dma_irq_error_reset_ctrl.sv
/*
 * Self-checking bench of the delay timer, error halt and reset control.
 * Assumes dma_ctrl_pkg and dma_engine_model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dma_ctrl_defines.svh"

module test_dma_irq_error_reset_ctrl;
    import dma_ctrl_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic regport_rstn_i = 1'b0;
    logic [`ADDR_W-1:0] reg_addr_i = '0;
    logic [`DATA_W-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic session_start_i = 1'b0;
    logic ioc_event_i = 1'b0;
    logic [`DATA_W-1:0] cur_desc_i = '0;
    logic cmd_valid_i = 1'b0;
    logic [`BCNT_W-1:0] cmd_byte_count_i = 23'h00_0040;
    logic data_resp_valid_i = 1'b0;
    logic [1:0] data_resp_i = 2'h0;
    logic desc_fetch_valid_i = 1'b0;
    logic desc_cmplt_i = 1'b0;
    logic desc_resp_valid_i = 1'b0;
    logic [1:0] desc_resp_i = 2'h0;
    logic busy = 1'b0;
    logic [3:0] drain = 4'h0;
    logic engine_idle_i, xfer_outstanding_i, halt_o, idle_o, irq_o, coalesce_reload_o;
    logic engine_flush_o;
    logic [2:0] desc_status_err_o;
    logic [`DATA_W-1:0] reg_rdata_o;
    logic [31:0] d;
    int miscompares = 0;
    int tests_run = 0;

    always #5 mclk_i = ~mclk_i;

    dma_engine_model u_dma_engine_model (.mclk_i(mclk_i), .rstn_i(rstn_i), .busy_req_i(busy),
        .drain_i(drain), .engine_idle_o(engine_idle_i), .xfer_outstanding_o(xfer_outstanding_i));

    dma_irq_error_reset_ctrl u_dma_irq_error_reset_ctrl (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .regport_rstn_i(regport_rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .session_start_i(session_start_i), .engine_idle_i(engine_idle_i),
        .xfer_outstanding_i(xfer_outstanding_i), .ioc_event_i(ioc_event_i),
        .cur_desc_i(cur_desc_i), .cmd_valid_i(cmd_valid_i), .cmd_byte_count_i(cmd_byte_count_i),
        .data_resp_valid_i(data_resp_valid_i), .data_resp_i(data_resp_i),
        .desc_fetch_valid_i(desc_fetch_valid_i), .desc_cmplt_i(desc_cmplt_i),
        .desc_resp_valid_i(desc_resp_valid_i), .desc_resp_i(desc_resp_i), .halt_o(halt_o),
        .idle_o(idle_o), .irq_o(irq_o), .coalesce_reload_o(coalesce_reload_o),
        .engine_flush_o(engine_flush_o), .desc_status_err_o(desc_status_err_o));

    // ============================================================
    // bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // one-cycle error event of kind k
    task automatic err(input int k);
        @(posedge mclk_i);
        cmd_valid_i <= (k == 0);
        cmd_byte_count_i <= (k == 0) ? `BCNT_ZERO : 23'h00_0040;
        data_resp_valid_i <= (k == 1) || (k == 2);
        data_resp_i <= (k == 1) ? `RESP_SLVERR : `RESP_DECERR;
        desc_fetch_valid_i <= (k == 3);
        desc_cmplt_i <= (k == 3);
        desc_resp_valid_i <= (k == 4) || (k == 5);
        desc_resp_i <= (k == 4) ? `RESP_SLVERR : `RESP_DECERR;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        data_resp_valid_i <= 1'b0;
        desc_fetch_valid_i <= 1'b0;
        desc_resp_valid_i <= 1'b0;
    endtask

    // ============================================================
    // scenarios
    task automatic t_delay(input logic [7:0] n, input logic fire);
        int k;
        logic seen;
        wr(`OFF_CTRL, {n, 24'h0} | (32'h1 << `CTRL_DLY_EN) | (32'h1 << `CTRL_IOC_EN));
        @(posedge mclk_i);
        session_start_i <= 1'b1;
        @(posedge mclk_i);
        session_start_i <= 1'b0;
        if (fire) begin
            cyc(2);
            rd(`OFF_STAT);
            chk(d[`HTS_LSB+:`HOLD_W] != 8'h00, 1'b1);
            busy <= 1'b1;
            cyc(4);
            rd(`OFF_STAT);
            chk(d[`HTS_LSB+:`HOLD_W], 8'h00);
            busy <= 1'b0;
        end
        seen = 1'b0;
        for (k = 0; k < 40 && !seen; k++) begin
            cyc(1);
            seen = coalesce_reload_o;
        end
        chk(seen, fire);
        if (fire) begin
            chk(k >= n && k <= n + 4, 1'b1);
            rd(`OFF_STAT);
            chk({d[`STAT_DLY], d[`HTS_LSB+:`HOLD_W]}, 9'h100);
            chk(irq_o, 1'b1);
            cyc(6);
            rd(`OFF_STAT);
            chk(d[`HTS_LSB+:`HOLD_W], 8'h00);
            wr(`OFF_STAT, 32'h1 << `STAT_DLY);
            cyc(2);
            chk(irq_o, 1'b0);
            @(posedge mclk_i);
            ioc_event_i <= 1'b1;
            @(posedge mclk_i);
            ioc_event_i <= 1'b0;
            cyc(2);
            chk(irq_o, 1'b1);
            wr(`OFF_STAT, 32'h1 << `STAT_IOC);
        end
        $display("test delay %0d done", n);
    endtask

    task automatic t_halt();
        wr(`OFF_CTRL, 32'h1 << `CTRL_ERR_EN);
        drain <= 4'h5;
        busy <= 1'b1;
        cur_desc_i <= 32'h0000_1a40;
        err(1);
        cur_desc_i <= 32'h0000_2b80;
        err(2);
        busy <= 1'b0;
        cyc(2);
        chk({halt_o, idle_o}, 2'b10);
        for (int i = 0; i < 20 && xfer_outstanding_i; i++) cyc(1);
        cyc(2);
        chk(idle_o, 1'b1);
        rd(`OFF_CDESC);
        chk(d, 32'h0000_1a40);
        rd(`OFF_STAT);
        chk(d[6:4], 3'b110);
        chk({desc_status_err_o, irq_o}, 4'b1101);
        cyc(4);
        chk(halt_o, 1'b1);
        wr(`OFF_CTRL, 32'h1 << `CTRL_SRST);
        cyc(2);
        chk(halt_o, 1'b0);
        rd(`OFF_STAT);
        chk(d[10:4], 7'h00);
        drain <= 4'h0;
        $display("test halt done");
    endtask

    task automatic t_kinds();
        int bpos[6] = '{`STAT_MINT, `STAT_MSLV, `STAT_MDEC, `STAT_CINT, `STAT_CSLV, `STAT_CDEC};
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        cyc(2);
        chk(halt_o, 1'b0);
        for (int i = 0; i < 6; i++) begin
            err(i);
            cyc(2);
            rd(`OFF_STAT);
            chk(d[bpos[i]], 1'b1);
            chk(desc_status_err_o, (i < 3) ? (3'b001 << i) : 3'b000);
            chk(halt_o, 1'b1);
            wr(`OFF_CTRL, 32'h1 << `CTRL_SRST);
            cyc(2);
        end
        $display("test error kinds done");
    endtask

    task automatic t_resets();
        wr(`OFF_CTRL, 32'h1 << `CTRL_ERR_EN);
        err(1);
        cyc(2);
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        cyc(3);
        chk({halt_o, irq_o}, 2'b00);
        cyc(6);
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        cyc(3);
        rd(`OFF_CTRL);
        chk(d, `CTRL_RST);
        err(5);
        cyc(2);
        @(posedge mclk_i);
        regport_rstn_i <= 1'b0;
        cyc(3);
        chk({halt_o, engine_flush_o}, 2'b01);
        cyc(6);
        @(posedge mclk_i);
        regport_rstn_i <= 1'b1;
        cyc(4);
        chk(engine_flush_o, 1'b0);
        rd(`OFF_STAT);
        chk(d[10:4], 7'h00);
        rd(`OFF_CDESC);
        chk(d, `CDESC_RST);
        $display("test resets done");
    endtask

    // ============================================================
    // run control
    task automatic end_sim();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        regport_rstn_i <= 1'b1;
        cyc(3);
        rd(`OFF_CTRL);
        chk(d, `CTRL_RST);
        rd(8'h0c);
        chk(d, 32'h0);
        t_delay(8'h00, 1'b0);
        t_delay(8'h06, 1'b1);
        t_halt();
        t_kinds();
        t_resets();
        end_sim();
    end
endmodule // test_dma_irq_error_reset_ctrl

`default_nettype wire
